// file: pkg/lookup_irq_if.sv
// interrupt status and mask group between register front end and irq bank
interface lookup_irq_if;
  logic [2:0] events;
  logic [2:0] clear;
  logic mask_wr;
  logic [2:0] mask_wdata;
  logic [2:0] status;
  logic [2:0] mask;
  logic irq;
  logic summary;
  modport bank (
    input events,
    input clear,
    input mask_wr,
    input mask_wdata,
    output status,
    output mask,
    output irq,
    output summary
  );
  modport ctrl (
    output events,
    output clear,
    output mask_wr,
    output mask_wdata,
    input status,
    input mask,
    input irq,
    input summary
  );
endinterface : lookup_irq_if

// file: pkg/lookup_regs_pkg.sv
// constants for the lookup engine control register group
package lookup_regs_pkg;
  // register offsets on the 12-bit switch register address
  localparam logic [11:0] ADDR_CTRL_ONE = 12'h311;
  localparam logic [11:0] ADDR_CTRL_TWO = 12'h312;
  localparam logic [11:0] ADDR_AGE_PERIOD = 12'h313;
  localparam logic [11:0] ADDR_IRQ_STATUS = 12'h314;
  localparam logic [11:0] ADDR_IRQ_MASK = 12'h315;
  // flush trigger bits of control one
  localparam int BIT_FLUSH_WHOLE = 5;
  localparam int BIT_FLUSH_MSTP = 4;
  // fields of control two
  localparam int BIT_RESERVED_TWO = 7;
  localparam int BIT_DTAG_TRAP = 6;
  localparam int BIT_DYN_FILTER = 5;
  localparam int BIT_STATIC_FILTER = 4;
  localparam int FLUSH_OPT_HI = 3;
  localparam int FLUSH_OPT_LO = 2;
  localparam int PRIO_HI = 1;
  localparam int PRIO_LO = 0;
  // flush option encodings
  localparam logic [1:0] FLUSH_NONE = 2'h0;
  localparam logic [1:0] FLUSH_DYNAMIC = 2'h1;
  localparam logic [1:0] FLUSH_STATIC = 2'h2;
  localparam logic [1:0] FLUSH_BOTH = 2'h3;
  // priority source encodings
  localparam logic [1:0] PRIO_DA = 2'h0;
  localparam logic [1:0] PRIO_SA = 2'h1;
  localparam logic [1:0] PRIO_HIGHER = 2'h2;
  localparam logic [1:0] PRIO_LOWER = 2'h3;
  // interrupt bit positions
  localparam int IRQ_LEARN_FAIL = 2;
  localparam int IRQ_ALMOST_FULL = 1;
  localparam int IRQ_WRITE_FAIL = 0;
  localparam int IRQ_BITS = 3;
  // reset values
  localparam logic [7:0] CTRL_TWO_RESET = 8'h00;
  localparam logic [7:0] AGE_PERIOD_RESET = 8'h4b;
  localparam logic [2:0] IRQ_STATUS_RESET = 3'h0;
  localparam logic [2:0] IRQ_MASK_RESET = 3'h7;
  // almost full bucket occupancy bounds
  localparam logic [2:0] ALMOST_FULL_MIN = 3'h2;
  localparam logic [2:0] ALMOST_FULL_MAX = 3'h3;
  // timing: age unit is one second at a 50 ns clock
  localparam int CLK_PERIOD_NS = 50;
  localparam int AGE_UNIT_NS = 1000000000;
  localparam int AGE_UNIT_CYCLES = AGE_UNIT_NS / CLK_PERIOD_NS;
endpackage : lookup_regs_pkg

// file: src/lookup_engine_control_regs.sv
// lookup engine control registers, flush control, forwarding and aging
module lookup_engine_control_regs #(
  parameter int PORTS = 7,
  parameter int PRIO_W = 3,
  parameter int AGE_UNIT_CYCLES = lookup_regs_pkg::AGE_UNIT_CYCLES
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [11:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [7:0] rdata,
  input wire logic lookup_valid,
  input wire logic lookup_hit,
  input wire logic hit_is_static,
  input wire logic reserved_mcast,
  input wire logic double_tag_mode,
  input wire logic [PORTS-1:0] table_port_map,
  input wire logic [PORTS-1:0] vlan_port_map,
  input wire logic [PORTS-1:0] host_port_map,
  input wire logic [PRIO_W-1:0] da_priority,
  input wire logic [PRIO_W-1:0] sa_priority,
  output logic fwd_valid,
  output logic [PORTS-1:0] fwd_port_map,
  output logic [PRIO_W-1:0] mac_address_priority,
  output logic flush_start,
  output logic flush_busy,
  output logic flush_whole,
  output logic flush_mstp,
  output logic [1:0] flush_scope,
  input wire logic flush_done,
  output logic age_step,
  input wire logic learn_fail_event,
  input wire logic static_write,
  input wire logic static_write_ok,
  input wire logic [2:0] bucket_valid_count,
  output logic lookup_engine_irq_summary,
  output logic irq
);
  typedef enum logic {FLUSH_IDLE, FLUSH_RUN} flush_state_t;

  logic rst_meta;
  logic rst_n;
  logic [7:0] ctrl_two;
  logic [7:0] age_period;
  flush_state_t flush_state;
  logic [31:0] sec_count;
  logic [7:0] period_count;
  lookup_irq_if irq_bus ();

  // reset release through two flip-flops
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  // address decode
  wire wr_ctrl_one = wr_en && (addr == lookup_regs_pkg::ADDR_CTRL_ONE);
  wire wr_ctrl_two = wr_en && (addr == lookup_regs_pkg::ADDR_CTRL_TWO);
  wire wr_age = wr_en && (addr == lookup_regs_pkg::ADDR_AGE_PERIOD);
  wire wr_status = wr_en && (addr == lookup_regs_pkg::ADDR_IRQ_STATUS);
  wire wr_mask = wr_en && (addr == lookup_regs_pkg::ADDR_IRQ_MASK);

  // control two fields
  wire dtag_trap = ctrl_two[lookup_regs_pkg::BIT_DTAG_TRAP];
  wire dyn_filter = ctrl_two[lookup_regs_pkg::BIT_DYN_FILTER];
  wire static_filter = ctrl_two[lookup_regs_pkg::BIT_STATIC_FILTER];
  wire [1:0] flush_opt = ctrl_two[lookup_regs_pkg::FLUSH_OPT_HI:lookup_regs_pkg::FLUSH_OPT_LO];
  wire [1:0] prio_sel = ctrl_two[lookup_regs_pkg::PRIO_HI:lookup_regs_pkg::PRIO_LO];

  // flush trigger decode, ignored while a flush runs
  wire trig_whole = wdata[lookup_regs_pkg::BIT_FLUSH_WHOLE];
  wire trig_mstp = wdata[lookup_regs_pkg::BIT_FLUSH_MSTP];
  wire trig_any = wr_ctrl_one && (trig_whole || trig_mstp) && (flush_state == FLUSH_IDLE);
  wire flush_go = trig_any && (flush_opt != lookup_regs_pkg::FLUSH_NONE);
  wire flush_end = (flush_state == FLUSH_RUN) && flush_done;

  // control two: software write, option cleared when a flush ends unless control two is written in that cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_two <= lookup_regs_pkg::CTRL_TWO_RESET;
    end else if (wr_ctrl_two) begin
      ctrl_two <= wdata;
    end else if (flush_end) begin
      ctrl_two[lookup_regs_pkg::FLUSH_OPT_HI:lookup_regs_pkg::FLUSH_OPT_LO] <=
        lookup_regs_pkg::FLUSH_NONE;
    end
  end

  // age period register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      age_period <= lookup_regs_pkg::AGE_PERIOD_RESET;
    end else if (wr_age) begin
      age_period <= wdata;
    end
  end

  // flush sequencer
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      flush_state <= FLUSH_IDLE;
    end else begin
      unique case (flush_state)
        FLUSH_IDLE: if (flush_go) flush_state <= FLUSH_RUN;
        FLUSH_RUN: if (flush_done) flush_state <= FLUSH_IDLE;
      endcase
    end
  end

  // flush outputs toward the table engine, scope latched at start
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      flush_start <= 1'b0;
      flush_busy <= 1'b0;
      flush_whole <= 1'b0;
      flush_mstp <= 1'b0;
      flush_scope <= lookup_regs_pkg::FLUSH_NONE;
    end else begin
      flush_start <= flush_go;
      flush_busy <= flush_go || (flush_busy && !flush_done);
      if (flush_go) begin
        flush_whole <= trig_whole;
        flush_mstp <= trig_mstp;
        flush_scope <= flush_opt;
      end else if (flush_end) begin
        flush_whole <= 1'b0;
        flush_mstp <= 1'b0;
        flush_scope <= lookup_regs_pkg::FLUSH_NONE;
      end
    end
  end

  // forwarding map selection
  wire [PORTS-1:0] and_map = table_port_map & vlan_port_map;
  wire trap_hit = dtag_trap && double_tag_mode && reserved_mcast;
  wire use_filter = lookup_hit && (hit_is_static ? static_filter : dyn_filter);
  wire [PORTS-1:0] next_fwd_map = trap_hit ? host_port_map :
                                  use_filter ? and_map : table_port_map;

  // priority source selection
  wire [PRIO_W-1:0] higher_prio = (da_priority > sa_priority) ? da_priority : sa_priority;
  wire [PRIO_W-1:0] lower_prio = (da_priority < sa_priority) ? da_priority : sa_priority;
  wire [PRIO_W-1:0] next_prio = (prio_sel == lookup_regs_pkg::PRIO_DA) ? da_priority :
                                (prio_sel == lookup_regs_pkg::PRIO_SA) ? sa_priority :
                                (prio_sel == lookup_regs_pkg::PRIO_HIGHER) ? higher_prio :
                                lower_prio;

  // lookup results, one cycle after the request
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fwd_valid <= 1'b0;
      fwd_port_map <= '0;
      mac_address_priority <= '0;
    end else begin
      fwd_valid <= lookup_valid;
      if (lookup_valid) begin
        fwd_port_map <= next_fwd_map;
        mac_address_priority <= next_prio;
      end
    end
  end

  // one-second tick and age period step
  wire sec_tick = (sec_count == 32'(AGE_UNIT_CYCLES - 1));
  wire period_last = (period_count >= (age_period - 8'h01));
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sec_count <= '0;
      period_count <= '0;
      age_step <= 1'b0;
    end else begin
      sec_count <= sec_tick ? '0 : sec_count + 32'h1;
      age_step <= sec_tick && (age_period != 8'h00) && period_last;
      if (sec_tick) begin
        period_count <= period_last ? 8'h00 : period_count + 8'h01;
      end
    end
  end

  // interrupt events and software access to the bank
  wire almost_full_hit = (bucket_valid_count >= lookup_regs_pkg::ALMOST_FULL_MIN) &&
                         (bucket_valid_count <= lookup_regs_pkg::ALMOST_FULL_MAX);
  assign irq_bus.events[lookup_regs_pkg::IRQ_LEARN_FAIL] = learn_fail_event;
  assign irq_bus.events[lookup_regs_pkg::IRQ_ALMOST_FULL] =
    static_write && static_write_ok && almost_full_hit;
  assign irq_bus.events[lookup_regs_pkg::IRQ_WRITE_FAIL] =
    static_write && !static_write_ok;
  assign irq_bus.clear = wr_status ? wdata[2:0] : 3'h0;
  assign irq_bus.mask_wr = wr_mask;
  assign irq_bus.mask_wdata = wdata[2:0];

  lookup_irq_bank u_irq_bank (
    .clk(clk),
    .rst_n(rst_n),
    .irq_bus(irq_bus)
  );

  // interrupt outputs come from the bank's flip-flops
  assign irq = irq_bus.irq;
  assign lookup_engine_irq_summary = irq_bus.summary;

  // read mux, reserved bits read zero except control two bit 7, which reads back as written
  wire [7:0] ctrl_one_view = {2'h0, flush_whole, flush_mstp, 4'h0};
  wire [7:0] read_word =
    (addr == lookup_regs_pkg::ADDR_CTRL_ONE) ? ctrl_one_view :
    (addr == lookup_regs_pkg::ADDR_CTRL_TWO) ? ctrl_two :
    (addr == lookup_regs_pkg::ADDR_AGE_PERIOD) ? age_period :
    (addr == lookup_regs_pkg::ADDR_IRQ_STATUS) ? {5'h00, irq_bus.status} :
    (addr == lookup_regs_pkg::ADDR_IRQ_MASK) ? {5'h00, irq_bus.mask} : 8'h00;

  // read data stand for the one cycle after the strobe
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata <= 8'h00;
    end else begin
      rdata <= rd_en ? read_word : 8'h00;
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  sequence flush_request_s;
    wr_ctrl_one && (trig_whole || trig_mstp) && !flush_busy;
  endsequence
  sequence flush_accept_s;
    flush_request_s ##0 (flush_opt != lookup_regs_pkg::FLUSH_NONE);
  endsequence

  chk_trap_host: assert property (
    lookup_valid && trap_hit |=> fwd_port_map == $past(host_port_map)
  ) else $error("reserved multicast not trapped to host");
  chk_dyn_filter: assert property (
    lookup_valid && !trap_hit && lookup_hit && !hit_is_static && dyn_filter
    |=> fwd_port_map == $past(and_map)
  ) else $error("dynamic hit not filtered by vlan map");
  chk_static_filter: assert property (
    lookup_valid && !trap_hit && lookup_hit && hit_is_static && !static_filter
    |=> fwd_port_map == $past(table_port_map)
  ) else $error("unfiltered static hit changed port map");
  chk_flush_scope: assert property (
    flush_accept_s |=> flush_start && flush_busy && (flush_scope == $past(flush_opt))
  ) else $error("flush scope not taken from option");
  chk_flush_kind: assert property (
    flush_accept_s ##0 trig_mstp |=> flush_mstp ##1 !flush_start
  ) else $error("spanning tree flush not started once");
  chk_flush_none: assert property (
    flush_request_s ##0 (flush_opt == lookup_regs_pkg::FLUSH_NONE)
    |=> !flush_start && !flush_busy
  ) else $error("flush started with option zero");
  chk_flush_clear: assert property (
    flush_end && !wr_ctrl_two |=> flush_opt == lookup_regs_pkg::FLUSH_NONE && !flush_busy
  ) else $error("option not zero after flush done");
  chk_prio_higher: assert property (
    lookup_valid && prio_sel == lookup_regs_pkg::PRIO_HIGHER
    |=> mac_address_priority == $past(higher_prio)
  ) else $error("higher priority source not chosen");
  chk_age_step: assert property (
    age_step |-> $past(sec_tick) && $past(age_period) != 8'h00
  ) else $error("age step without a second tick");
  chk_write_fail: assert property (
    static_write && !static_write_ok |=> irq_bus.status[lookup_regs_pkg::IRQ_WRITE_FAIL]
  ) else $error("write failure not flagged");
  chk_almost_full: assert property (
    static_write && static_write_ok && bucket_valid_count == 3'h2
    |=> irq_bus.status[lookup_regs_pkg::IRQ_ALMOST_FULL]
  ) else $error("almost full not flagged");

  // plain dynamic hit and filtered static hit
  chk_dyn_plain: assert property (
    lookup_valid && !trap_hit && lookup_hit && !hit_is_static && !dyn_filter
    |=> fwd_port_map == $past(table_port_map)
  ) else $error("unfiltered dynamic hit changed port map");
  chk_static_and: assert property (
    lookup_valid && !trap_hit && lookup_hit && hit_is_static && static_filter
    |=> fwd_port_map == $past(and_map)
  ) else $error("static hit not filtered by vlan map");
  // whole-table trigger starts a flush, a running flush is not restarted
  chk_whole_flush: assert property (
    flush_accept_s ##0 trig_whole |=> flush_whole && flush_busy
  ) else $error("whole table flush not started");
  chk_busy_refuse: assert property (
    flush_busy && !flush_done |=> !flush_start
  ) else $error("flush restarted while busy");
  // unused status bits always read back as zero
  chk_reserved_zero: assert property (
    rd_en && addr == lookup_regs_pkg::ADDR_IRQ_STATUS |=> rdata[7:3] == 5'h00
  ) else $error("reserved status bits read nonzero");
endmodule : lookup_engine_control_regs

// file: src/lookup_irq_bank.sv
// sticky lookup table interrupt status, mask and interrupt outputs
module lookup_irq_bank (
  input wire logic clk,
  input wire logic rst_n,
  lookup_irq_if.bank irq_bus
);
  logic [2:0] next_status;
  logic [2:0] next_mask;
  logic [2:0] pending;

  // set wins over a same-cycle clear, status holds until cleared
  assign next_status = (irq_bus.status & ~irq_bus.clear) | irq_bus.events;
  assign next_mask = irq_bus.mask_wr ? irq_bus.mask_wdata : irq_bus.mask;
  // a mask bit of one blocks its source
  assign pending = next_status & ~next_mask;

  // status, mask and both interrupt levels
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_bus.status <= lookup_regs_pkg::IRQ_STATUS_RESET;
      irq_bus.mask <= lookup_regs_pkg::IRQ_MASK_RESET;
      irq_bus.irq <= 1'b0;
      irq_bus.summary <= 1'b0;
    end else begin
      irq_bus.status <= next_status;
      irq_bus.mask <= next_mask;
      irq_bus.irq <= |pending;
      irq_bus.summary <= |next_status;
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  chk_status_sticky: assert property (
    irq_bus.status[0] && !irq_bus.clear[0] |=> irq_bus.status[0]
  ) else $error("write fail status dropped without a clear");
  chk_event_sets: assert property (
    irq_bus.events[2] |=> irq_bus.status[2] && irq_bus.summary
  ) else $error("learn fail event not recorded");
  chk_summary_or: assert property (
    irq_bus.summary == |irq_bus.status
  ) else $error("summary is not the or of status");
  chk_irq_masked: assert property (
    irq_bus.irq == |(irq_bus.status & ~irq_bus.mask)
  ) else $error("interrupt disagrees with status and mask");
endmodule : lookup_irq_bank

// file: verif/lookup_engine_control_regs_bench.sv
// self-checking bench for the lookup engine control register group
module lookup_engine_control_regs_bench;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int AGE_UNIT = 10;
  typedef struct {
    logic [7:0] c2;
    logic hit, st, rmc, dt;
    logic [6:0] tbl, vl, em;
    logic [2:0] da, sa, ep;
  } row_t;
  logic clk = 1'b0;
  logic reset_n = 1'b1;
  logic [11:0] addr = 12'h000;
  logic [7:0] wdata = 8'h00;
  logic wr_en = 1'b0, rd_en = 1'b0;
  logic [7:0] rdata;
  logic lookup_valid = 1'b0, lookup_hit = 1'b0, hit_is_static = 1'b0;
  logic reserved_mcast = 1'b0, double_tag_mode = 1'b0;
  logic [6:0] table_port_map = 7'h00, vlan_port_map = 7'h00, host_port_map = 7'h40;
  logic [2:0] da_priority = 3'h0, sa_priority = 3'h0, mac_address_priority;
  logic fwd_valid, flush_start, flush_busy, flush_whole, flush_mstp, age_step;
  logic [6:0] fwd_port_map;
  logic [1:0] flush_scope;
  logic flush_done = 1'b0, learn_fail_event = 1'b0, static_write = 1'b0, static_write_ok = 1'b0;
  logic [2:0] bucket_valid_count = 3'h0;
  logic lookup_engine_irq_summary, irq;
  int failures = 0;
  int checked = 0;
  row_t rows [10];
  logic [7:0] trig;
  int n;

  lookup_engine_control_regs #(.PORTS(7), .PRIO_W(3), .AGE_UNIT_CYCLES(AGE_UNIT)) dut (
    .clk(clk), .reset_n(reset_n), .addr(addr), .wdata(wdata), .wr_en(wr_en),
    .rd_en(rd_en), .rdata(rdata), .lookup_valid(lookup_valid), .lookup_hit(lookup_hit),
    .hit_is_static(hit_is_static), .reserved_mcast(reserved_mcast),
    .double_tag_mode(double_tag_mode), .table_port_map(table_port_map),
    .vlan_port_map(vlan_port_map), .host_port_map(host_port_map),
    .da_priority(da_priority), .sa_priority(sa_priority), .fwd_valid(fwd_valid),
    .fwd_port_map(fwd_port_map), .mac_address_priority(mac_address_priority),
    .flush_start(flush_start), .flush_busy(flush_busy), .flush_whole(flush_whole),
    .flush_mstp(flush_mstp), .flush_scope(flush_scope), .flush_done(flush_done),
    .age_step(age_step), .learn_fail_event(learn_fail_event), .static_write(static_write),
    .static_write_ok(static_write_ok), .bucket_valid_count(bucket_valid_count),
    .lookup_engine_irq_summary(lookup_engine_irq_summary), .irq(irq)
  );

  // free running clock, 50 ns period
  always #25 clk = ~clk;

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checked = checked + 1;
    if (seen !== exp) begin
      failures = failures + 1;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic summarize;
    if (failures == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : summarize

  // reset held two cycles, first access on the fourth edge after release
  task automatic do_reset;
    reset_n <= 1'b0;
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    repeat (3) @(posedge clk);
  endtask : do_reset

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge clk);
    wr_en <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr_en <= 1'b0;
    @(negedge clk);
  endtask : wr

  task automatic rd(input logic [11:0] a, input logic [7:0] e);
    @(posedge clk);
    rd_en <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd_en <= 1'b0;
    @(negedge clk);
    check(rdata, e);
  endtask : rd

  // one-cycle event pulse toward the status bank
  task automatic ev(input logic lf, input logic sw, input logic ok, input logic [2:0] cnt);
    @(posedge clk);
    learn_fail_event <= lf;
    static_write <= sw;
    static_write_ok <= ok;
    bucket_valid_count <= cnt;
    @(posedge clk);
    learn_fail_event <= 1'b0;
    static_write <= 1'b0;
    @(negedge clk);
  endtask : ev

  // watchdog well beyond the expected run length
  initial begin
    #2000000;
    failures = failures + 1;
    summarize();
  end

  initial begin
    rows = '{
      '{8'h00, 1, 0, 0, 0, 7'h7f, 7'h0f, 7'h7f, 3'h3, 3'h5, 3'h3},
      '{8'h20, 1, 0, 0, 0, 7'h7f, 7'h0f, 7'h0f, 3'h3, 3'h5, 3'h3},
      '{8'h20, 1, 1, 0, 0, 7'h7f, 7'h0f, 7'h7f, 3'h3, 3'h5, 3'h3},
      '{8'h11, 1, 1, 0, 0, 7'h3c, 7'h27, 7'h24, 3'h3, 3'h5, 3'h5},
      '{8'h12, 1, 0, 0, 0, 7'h3c, 7'h27, 7'h3c, 3'h3, 3'h5, 3'h5},
      '{8'h33, 0, 0, 0, 0, 7'h55, 7'h0f, 7'h55, 3'h6, 3'h2, 3'h2},
      '{8'h32, 1, 1, 0, 0, 7'h55, 7'h0f, 7'h05, 3'h6, 3'h2, 3'h6},
      '{8'h40, 1, 0, 1, 1, 7'h7f, 7'h0f, 7'h40, 3'h0, 3'h0, 3'h0},
      '{8'h40, 1, 0, 1, 0, 7'h7f, 7'h0f, 7'h7f, 3'h0, 3'h0, 3'h0},
      '{8'hf0, 1, 0, 1, 1, 7'h7f, 7'h0f, 7'h40, 3'h0, 3'h0, 3'h0}
    };
    do_reset();
    // reset values and an unmapped place
    rd(lookup_regs_pkg::ADDR_CTRL_TWO, 8'h00);
    rd(lookup_regs_pkg::ADDR_AGE_PERIOD, 8'h4b);
    rd(lookup_regs_pkg::ADDR_IRQ_STATUS, 8'h00);
    rd(lookup_regs_pkg::ADDR_IRQ_MASK, 8'h07);
    rd(12'h320, 8'h00);
    // lookup table: filters on and off, trap, priority sources
    for (int i = 0; i < 10; i++) begin
      wr(lookup_regs_pkg::ADDR_CTRL_TWO, rows[i].c2);
      rd(lookup_regs_pkg::ADDR_CTRL_TWO, rows[i].c2);
      @(posedge clk);
      lookup_valid <= 1'b1;
      lookup_hit <= rows[i].hit;
      hit_is_static <= rows[i].st;
      reserved_mcast <= rows[i].rmc;
      double_tag_mode <= rows[i].dt;
      table_port_map <= rows[i].tbl;
      vlan_port_map <= rows[i].vl;
      da_priority <= rows[i].da;
      sa_priority <= rows[i].sa;
      @(posedge clk);
      lookup_valid <= 1'b0;
      @(negedge clk);
      check(8'(fwd_valid), 8'h01);
      check(8'(fwd_port_map), 8'(rows[i].em));
      check(8'(mac_address_priority), 8'(rows[i].ep));
    end
    // sticky status, summary and mask gating
    ev(1'b0, 1'b1, 1'b0, 3'h4);
    rd(lookup_regs_pkg::ADDR_IRQ_STATUS, 8'h01);
    check(8'(lookup_engine_irq_summary), 8'h01);
    check(8'(irq), 8'h00);
    wr(lookup_regs_pkg::ADDR_IRQ_MASK, 8'hfe);
    rd(lookup_regs_pkg::ADDR_IRQ_MASK, 8'h06);
    check(8'(irq), 8'h01);
    ev(1'b1, 1'b0, 1'b0, 3'h0);
    rd(lookup_regs_pkg::ADDR_IRQ_STATUS, 8'h05);
    wr(lookup_regs_pkg::ADDR_IRQ_STATUS, 8'h01);
    rd(lookup_regs_pkg::ADDR_IRQ_STATUS, 8'h04);
    check(8'(irq), 8'h00);
    check(8'(lookup_engine_irq_summary), 8'h01);
    wr(lookup_regs_pkg::ADDR_IRQ_STATUS, 8'hff);
    check(8'(lookup_engine_irq_summary), 8'h00);
    // almost full only for 2 or 3 entries before a good static write
    for (int c = 0; c < 5; c++) begin
      ev(1'b0, 1'b1, 1'b1, 3'(c));
      rd(lookup_regs_pkg::ADDR_IRQ_STATUS, (c == 2 || c == 3) ? 8'h02 : 8'h00);
      wr(lookup_regs_pkg::ADDR_IRQ_MASK, 8'h05);
      check(8'(irq), (c == 2 || c == 3) ? 8'h01 : 8'h00);
      wr(lookup_regs_pkg::ADDR_IRQ_STATUS, 8'hff);
    end
    // event in the clear cycle keeps its status bit
    ev(1'b0, 1'b1, 1'b0, 3'h0);
    @(posedge clk);
    wr_en <= 1'b1;
    addr <= lookup_regs_pkg::ADDR_IRQ_STATUS;
    wdata <= 8'h01;
    static_write <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
    static_write <= 1'b0;
    @(negedge clk);
    rd(lookup_regs_pkg::ADDR_IRQ_STATUS, 8'h01);
    wr(lookup_regs_pkg::ADDR_IRQ_STATUS, 8'h01);
    rd(lookup_regs_pkg::ADDR_IRQ_STATUS, 8'h00);
    // flush triggers under each option, refused while busy
    for (int o = 1; o < 4; o++) begin
      trig = (o == 1) ? 8'h20 : (o == 2) ? 8'h10 : 8'h30;
      wr(lookup_regs_pkg::ADDR_CTRL_TWO, 8'(o << 2));
      wr(lookup_regs_pkg::ADDR_CTRL_ONE, trig);
      check(8'(flush_start), 8'h01);
      check(8'(flush_scope), 8'(o));
      check(8'({flush_whole, flush_mstp}), 8'(trig[5:4]));
      rd(lookup_regs_pkg::ADDR_CTRL_ONE, trig);
      wr(lookup_regs_pkg::ADDR_CTRL_ONE, 8'h30);
      check(8'(flush_start), 8'h00);
      check(8'(flush_busy), 8'h01);
      @(posedge clk);
      flush_done <= 1'b1;
      @(posedge clk);
      flush_done <= 1'b0;
      @(negedge clk);
      check(8'({flush_busy, flush_scope}), 8'h00);
      rd(lookup_regs_pkg::ADDR_CTRL_TWO, 8'h00);
      rd(lookup_regs_pkg::ADDR_CTRL_ONE, 8'h00);
    end
    wr(lookup_regs_pkg::ADDR_CTRL_ONE, 8'h20);
    check(8'({flush_start, flush_busy}), 8'h00);
    // age step spacing follows the age period
    wr(lookup_regs_pkg::ADDR_AGE_PERIOD, 8'h03);
    n = 0;
    while (age_step !== 1'b1 && n < 200) begin
      @(negedge clk);
      n++;
    end
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (age_step !== 1'b1 && n < 200);
    check(8'(n), 8'(3 * AGE_UNIT));
    wr(lookup_regs_pkg::ADDR_AGE_PERIOD, 8'h00);
    n = 0;
    repeat (100) begin
      @(negedge clk);
      if (age_step !== 1'b0) n++;
    end
    check(8'(n), 8'h00);
    // second reset in mid-run restores reset values
    wr(lookup_regs_pkg::ADDR_CTRL_TWO, 8'hff);
    @(posedge clk);
    do_reset();
    rd(lookup_regs_pkg::ADDR_CTRL_TWO, 8'h00);
    rd(lookup_regs_pkg::ADDR_AGE_PERIOD, 8'h4b);
    rd(lookup_regs_pkg::ADDR_IRQ_MASK, 8'h07);
    summarize();
  end
endmodule : lookup_engine_control_regs_bench
